// ### dv/sss_ctrl_model.sv
// Behavioural memory controller driving the device pins
`timescale 1ns/100ps
`default_nettype none
module sss_ctrl_model
  import sss_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  output logic              pos_timing_in,
  output logic              neg_timing_in,
  output logic              write_port_select_n,
  output logic              read_port_select_n,
  output logic [ADDR_W-1:0] addr_in,
  output logic [DATA_W-1:0] write_bus_in,
  output logic [LANES-1:0]  byte_lane_select_n,
  output logic              pll_disable_n
);
  logic [3:0]        cnt_reg;
  logic              run_reg;
  logic [DATA_W-1:0] pend_d;
  logic [LANES-1:0]  pend_l;
  // Clock pins low in reset; a K period of 16 clk keeps far below the legacy ceiling
  assign pos_timing_in = run_reg & ~cnt_reg[3];
  assign neg_timing_in = run_reg & cnt_reg[3];
  initial begin
    cnt_reg = 4'h9;
    run_reg = 1'b0;
    pll_disable_n = 1'b1;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    addr_in = '0;
    write_bus_in = '0;
    byte_lane_select_n = 2'h3;
    pend_d = '0;
    pend_l = 2'h3;
  end
  always @(negedge clk) begin
    cnt_reg <= rst ? 4'h9 : cnt_reg + 4'h1;
    run_reg <= !rst;
  end
  task automatic wait_at(input logic [3:0] v);
    do @(negedge clk); while (cnt_reg !== v);
  endtask
  // Two K periods: command at the first K rise, beats mid half period before each edge
  task automatic k2(input logic w_n, input logic r_n, input logic [ADDR_W-1:0] a,
                    input logic [4*DATA_W-1:0] d, input logic [4*LANES-1:0] l);
    wait_at(4'hB);
    write_port_select_n <= w_n;
    read_port_select_n <= r_n;
    addr_in <= a;
    write_bus_in <= pend_d;
    byte_lane_select_n <= pend_l;
    for (int i = 0; i < 3; i++) begin
      wait_at(i[0] ? 4'hB : 4'h3);
      write_port_select_n <= 1'b1;
      read_port_select_n <= 1'b1;
      addr_in <= ~a;
      write_bus_in <= d[i*DATA_W +: DATA_W];
      byte_lane_select_n <= l[i*LANES +: LANES];
    end
    pend_d = d[3*DATA_W +: DATA_W];
    pend_l = l[3*LANES +: LANES];
  endtask
endmodule // sss_ctrl_model
`default_nettype wire

// ### dv/sss_iface_chk.sv
// Pin-level assertions for the split-port burst memory interface
`timescale 1ns/100ps
`default_nettype none
module sss_iface_chk
  import sss_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              pos_timing_in,
  input wire logic              neg_timing_in,
  input wire logic              write_port_select_n,
  input wire logic              read_port_select_n,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] write_bus_in,
  input wire logic [LANES-1:0]  byte_lane_select_n,
  input wire logic              pll_disable_n,
  input wire logic [DATA_W-1:0] read_bus_out,
  input wire logic              read_bus_oe_n,
  input wire logic              output_valid_flag,
  input wire logic              echo_strobe_out,
  input wire logic              echo_strobe_n_out
);
  // Clk counts from a sampled read command to its first beat, for an 8-clk K half period
  localparam int LAT_PLL   = 43;
  localparam int LAT_NOPLL = 19;
  logic       pos_q;
  logic       rd_k;
  logic [7:0] idle_reg;
  assign rd_k = pos_timing_in & ~pos_q & ~read_port_select_n;
  always_ff @(posedge clk) begin
    pos_q <= pos_timing_in;
    if (rst || rd_k) idle_reg <= 8'h00;
    else if (idle_reg != 8'hFF) idle_reg <= idle_reg + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  echo_pos_a: assert property (echo_strobe_out == $past(pos_timing_in, 3))
    else $error("positive echo out of step");
  echo_neg_a: assert property (echo_strobe_n_out == $past(neg_timing_in, 3))
    else $error("negative echo out of step");
  valid_drive_a: assert property (output_valid_flag |-> !read_bus_oe_n)
    else $error("valid while released");
  valid_align_a: assert property ($changed(output_valid_flag) |-> $changed(echo_strobe_out))
    else $error("valid not aligned to echo");
  data_hold_a: assert property (!$changed(echo_strobe_out) |-> $stable(read_bus_out))
    else $error("read data moved between beats");
  pll_lat_a: assert property (rd_k && pll_disable_n |-> ##LAT_PLL
    output_valid_flag && $changed(echo_strobe_out)) else $error("wrong read latency");
  nopll_lat_a: assert property (rd_k && !pll_disable_n |-> ##LAT_NOPLL
    output_valid_flag && $changed(echo_strobe_out)) else $error("wrong legacy latency");
  oe_release_a: assert property ($fell(output_valid_flag) |-> ##[0:8] $rose(read_bus_oe_n))
    else $error("output not released");
  idle_off_a: assert property (idle_reg > 8'h5A |-> read_bus_oe_n)
    else $error("idle port drives data");
  cover property ($rose(output_valid_flag) && pll_disable_n);
  cover property ($rose(output_valid_flag) && !pll_disable_n);
  cover property ($rose(read_bus_oe_n));
endmodule // sss_iface_chk
bind sss_iface sss_iface_chk chk_u (
  .clk, .rst, .pos_timing_in, .neg_timing_in, .write_port_select_n, .read_port_select_n,
  .addr_in, .write_bus_in, .byte_lane_select_n, .pll_disable_n, .read_bus_out,
  .read_bus_oe_n, .output_valid_flag, .echo_strobe_out, .echo_strobe_n_out);
`default_nettype wire

// ### dv/tb_sync_sram_split_port_iface.sv
// Self-checking bench for the split-port burst memory interface
`timescale 1ns/100ps
`default_nettype none
module tb_sync_sram_split_port_iface
  import sss_pkg::*;
;
  typedef struct packed {
    logic                w_n;
    logic                r_n;
    logic [ADDR_W-1:0]   a;
    logic [4*DATA_W-1:0] d;
    logic [4*LANES-1:0]  l;
  } sss_row_type;
  logic clk, rst, pos_timing_in, neg_timing_in, write_port_select_n, read_port_select_n;
  logic pll_disable_n, read_bus_oe_n, output_valid_flag, echo_strobe_out, echo_strobe_n_out;
  logic              echo_q;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] write_bus_in, read_bus_out, e;
  logic [LANES-1:0]  byte_lane_select_n;
  logic [DATA_W-1:0] ref_m [bit [WORD_ADDR_W-1:0]];
  logic [DATA_W-1:0] exp_q [$];
  int                n_mismatch = 0;
  int                compares = 0;
  int                cyc = 0;
  sss_row_type rows [8] = '{
    '{1'b0, 1'b1, 20'h0_0001, 72'hA5_1234_5678_9ABC_DEF0, 8'h00},
    '{1'b0, 1'b1, 20'h0_0002, 72'h3C_0FED_CBA9_8765_4321, 8'h00},
    '{1'b0, 1'b1, 20'h0_0002, 72'hFF_FFFF_FFFF_FFFF_FFFF, 8'hE4},
    '{1'b1, 1'b1, 20'h0_0002, '0, 8'h00},
    '{1'b1, 1'b0, 20'h0_0001, 72'h5A_5A5A_5A5A_5A5A_5A5A, 8'h00},
    '{1'b1, 1'b0, 20'h0_0002, '0, 8'h00},
    '{1'b1, 1'b1, 20'h0_0001, '0, 8'h00},
    '{1'b1, 1'b0, 20'h0_0002, '0, 8'h00}
  };
  sss_iface dut_u (.clk, .rst, .pos_timing_in, .neg_timing_in, .write_port_select_n,
    .read_port_select_n, .addr_in, .write_bus_in, .byte_lane_select_n, .pll_disable_n,
    .read_bus_out, .read_bus_oe_n, .output_valid_flag, .echo_strobe_out, .echo_strobe_n_out);
  sss_ctrl_model ctl_u (.clk, .rst, .pos_timing_in, .neg_timing_in, .write_port_select_n,
    .read_port_select_n, .addr_in, .write_bus_in, .byte_lane_select_n, .pll_disable_n);
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reference memory follows lane masks; reads queue four sequential words
  task automatic run_row(input sss_row_type r);
    for (int b = 0; b < 4; b++) begin
      for (int j = 0; j < LANES; j++)
        if (!r.w_n && !r.l[b*LANES+j])
          ref_m[{r.a, 2'(b)}][j*LANE_W +: LANE_W] = r.d[b*DATA_W+j*LANE_W +: LANE_W];
      if (!r.r_n) exp_q.push_back(ref_m[{r.a, 2'(b)}]);
    end
    ctl_u.k2(r.w_n, r.r_n, r.a, r.d, r.l);
  endtask
  task automatic idle(input int n);
    repeat (n) ctl_u.k2(1'b1, 1'b1, '0, '0, '0);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  // Each echo step with valid high carries one beat; a beat with none expected fails
  always @(negedge clk) begin
    if (!rst && echo_strobe_out !== echo_q && output_valid_flag === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
      chk(read_bus_out, e);
    end
    echo_q = echo_strobe_out;
  end
  initial begin
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst <= 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    idle(3);
    chk(DATA_W'(exp_q.size()), '0);
    ctl_u.pll_disable_n <= 1'b0;
    run_row(rows[7]);
    idle(3);
    chk(DATA_W'(exp_q.size()), '0);
    ctl_u.pll_disable_n <= 1'b1;
    run_row(rows[4]);
    rst <= 1'b1;
    exp_q.delete();
    repeat (3) @(negedge clk);
    chk(read_bus_out, RD_DATA_RESET);
    chk(DATA_W'(read_bus_oe_n), DATA_W'(OE_N_RESET));
    chk(DATA_W'(output_valid_flag), '0);
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    idle(4);
    results();
  end
endmodule // tb_sync_sram_split_port_iface
`default_nettype wire

// ### logic/sss_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
`default_nettype none
module sss_fifo
  import sss_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } sss_fifo_state_type;

  sss_fifo_state_type st_reg;
  sss_fifo_state_type st_next;
  logic               push;
  logic               pop;

  assign in_ready  = (st_reg.cnt != FULL_CNT);
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = st_reg.mem[st_reg.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp             = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_next.cnt = st_reg.cnt + 1'b1;
      2'b01:   st_next.cnt = st_reg.cnt - 1'b1;
      default: st_next.cnt = st_reg.cnt;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // sss_fifo
`default_nettype wire

// ### logic/sss_iface.sv
// Device-side logic of the split-port burst-of-four synchronous memory
`timescale 1ns/100ps
`default_nettype none
module sss_iface
  import sss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              pos_timing_in,
  input  wire logic              neg_timing_in,
  input  wire logic              write_port_select_n,
  input  wire logic              read_port_select_n,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] write_bus_in,
  input  wire logic [LANES-1:0]  byte_lane_select_n,
  input  wire logic              pll_disable_n,
  output logic [DATA_W-1:0]      read_bus_out,
  output logic                   read_bus_oe_n,
  output logic                   output_valid_flag,
  output logic                   echo_strobe_out,
  output logic                   echo_strobe_n_out
);

  typedef struct packed {
    logic                   k;
    logic                   kn;
    logic                   wsel_n;
    logic                   rsel_n;
    logic                   pll_n;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      data;
    logic [LANES-1:0]       lane_n;
  } sss_pins_type;

  typedef struct packed {
    sss_pins_type           s1;
    sss_pins_type           s2;
    logic                   k_prev;
    logic                   kn_prev;
    logic [2:0]             wr_left;
    logic [WORD_ADDR_W-1:0] wr_addr;
    logic [PIPE_LEN-1:0]    rd_pipe;
    sss_fetch_type          fetch;
    logic [WORD_ADDR_W-1:0] fetch_addr;
    logic [2:0]             fetch_left;
    logic                   mem_rd_pend;
    logic [DATA_W-1:0]      q;
    logic                   oe_n;
    logic                   valid;
    logic                   echo_p;
    logic                   echo_n;
  } sss_state_type;

  sss_state_type          st_reg;
  sss_state_type          st_next;
  sss_pins_type           pins;

  logic                   k_rise;
  logic                   kn_rise;
  logic                   half_tick;
  logic                   wr_cmd;
  logic                   rd_cmd;
  logic                   wr_beat;
  logic                   rd_beat;
  logic                   mem_issue;

  logic                   wf_in_ready;
  logic                   wf_out_valid;
  logic                   wf_out_ready;
  logic [WR_ENTRY_W-1:0]  wf_in_data;
  logic [WR_ENTRY_W-1:0]  wf_out_data;
  logic                   rf_in_ready;
  logic                   rf_out_valid;
  logic [DATA_W-1:0]      rf_out_data;
  logic [DATA_W-1:0]      mem_rd_data;

  assign pins = '{k: pos_timing_in, kn: neg_timing_in, wsel_n: write_port_select_n,
                  rsel_n: read_port_select_n, pll_n: pll_disable_n, addr: addr_in,
                  data: write_bus_in, lane_n: byte_lane_select_n};

  // Edge detection looks only at second and third stages
  assign k_rise    = st_reg.s2.k & ~st_reg.k_prev;
  assign kn_rise   = st_reg.s2.kn & ~st_reg.kn_prev;
  assign half_tick = k_rise | kn_rise;
  assign wr_cmd    = k_rise & ~st_reg.s2.wsel_n;
  assign rd_cmd    = k_rise & ~st_reg.s2.rsel_n;
  assign wr_beat   = half_tick & (st_reg.wr_left != 3'h0);

  // Read beats fall at fixed half-tick offsets after the command
  always_comb begin
    logic [PIPE_LEN-1:0] pipe_sh;
    pipe_sh = {st_reg.rd_pipe[PIPE_LEN-2:0], rd_cmd};
    if (st_reg.s2.pll_n) begin
      rd_beat = half_tick & (|pipe_sh[LAT_PLL_HALF +: 4]);
    end else begin
      rd_beat = half_tick & (|pipe_sh[LAT_NOPLL_HALF +: 4]);
    end
  end

  // Deselected write port: no burst starts and its address is unused; data is pushed only on beats of a burst in flight
  assign wf_in_data = {st_reg.wr_addr, st_reg.s2.lane_n, st_reg.s2.data};

  // Reads own the array; a full write queue blocks new fetches so writes drain
  assign mem_issue    = (st_reg.fetch == SSS_FETCH_RUN) & rf_in_ready & wf_in_ready;
  assign wf_out_ready = ~mem_issue;

  sss_fifo #(
    .W     (WR_ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (wr_beat),
    .in_ready  (wf_in_ready),
    .in_data   (wf_in_data),
    .out_valid (wf_out_valid),
    .out_ready (wf_out_ready),
    .out_data  (wf_out_data)
  );

  sss_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (st_reg.mem_rd_pend),
    .in_ready  (rf_in_ready),
    .in_data   (mem_rd_data),
    .out_valid (rf_out_valid),
    .out_ready (rd_beat),
    .out_data  (rf_out_data)
  );

  sss_mem u_mem (
    .clk        (clk),
    .rst        (rst),
    .rd_en      (mem_issue),
    .rd_addr    (st_reg.fetch_addr),
    .rd_data    (mem_rd_data),
    .wr_en      (wf_out_valid & wf_out_ready),
    .wr_addr    (wf_out_data[WR_ENTRY_W-1 -: WORD_ADDR_W]),
    .wr_data    (wf_out_data[DATA_W-1:0]),
    .wr_lane_en (~wf_out_data[DATA_W +: LANES])
  );

  always_comb begin
    st_next         = st_reg;
    st_next.s1      = pins;
    st_next.s2      = st_reg.s1;
    st_next.k_prev  = st_reg.s2.k;
    st_next.kn_prev = st_reg.s2.kn;
    st_next.echo_p  = st_reg.s2.k;
    st_next.echo_n  = st_reg.s2.kn;
    st_next.mem_rd_pend = mem_issue;

    // Write burst: each of the four half ticks after the command takes one beat
    if (wr_beat) begin
      st_next.wr_left = st_reg.wr_left - 3'h1;
      st_next.wr_addr[BEAT_W-1:0] = st_reg.wr_addr[BEAT_W-1:0] + 2'h1;
    end
    if (wr_cmd) begin
      st_next.wr_addr = {st_reg.s2.addr, 2'b00};
      st_next.wr_left = BURST_LEN;
    end

    if (half_tick) begin
      st_next.rd_pipe = {st_reg.rd_pipe[PIPE_LEN-2:0], rd_cmd};
    end

    // Fetch four sequential words per read command
    case (st_reg.fetch)
      SSS_FETCH_IDLE: begin
        st_next.fetch = SSS_FETCH_IDLE;
      end
      SSS_FETCH_RUN: begin
        if (mem_issue) begin
          st_next.fetch_addr[BEAT_W-1:0] = st_reg.fetch_addr[BEAT_W-1:0] + 2'h1;
          st_next.fetch_left = st_reg.fetch_left - 3'h1;
          if (st_reg.fetch_left == 3'h1) begin
            st_next.fetch = SSS_FETCH_IDLE;
          end
        end
      end
      default: begin
        st_next.fetch = SSS_FETCH_IDLE;
      end
    endcase
    if (rd_cmd) begin
      st_next.fetch      = SSS_FETCH_RUN;
      st_next.fetch_addr = {st_reg.s2.addr, 2'b00};
      st_next.fetch_left = BURST_LEN;
    end

    // Output drive, data and valid change only on half ticks
    if (rd_beat) begin
      st_next.q     = rf_out_data;
      st_next.oe_n  = 1'b0;
      st_next.valid = rf_out_valid;
    end else if (half_tick) begin
      st_next.valid = 1'b0;
      if (k_rise) begin
        st_next.oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.fetch <= SSS_FETCH_IDLE;
      st_reg.q     <= RD_DATA_RESET;
      st_reg.oe_n  <= OE_N_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign read_bus_out      = st_reg.q;
  assign read_bus_oe_n     = st_reg.oe_n;
  assign output_valid_flag = st_reg.valid;
  assign echo_strobe_out   = st_reg.echo_p;
  assign echo_strobe_n_out = st_reg.echo_n;

endmodule // sss_iface
`default_nettype wire

// ### logic/sss_mem.sv
// Storage array with per-lane write enables and registered read data
`timescale 1ns/100ps
`default_nettype none
module sss_mem
  import sss_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   rd_en,
  input  wire logic [WORD_ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0]           rd_data,
  input  wire logic                   wr_en,
  input  wire logic [WORD_ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0]      wr_data,
  input  wire logic [LANES-1:0]       wr_lane_en
);

  typedef struct packed {
    logic [DATA_W-1:0] rd_data;
  } sss_mem_state_type;

  // Beat bits are the low two bits of the word address into one 4M-word array
  logic [DATA_W-1:0] mem [0:(2**WORD_ADDR_W)-1];
  sss_mem_state_type st_reg;
  sss_mem_state_type st_next;

  assign rd_data = st_reg.rd_data;

  always_ff @(posedge clk) begin
    for (int g = 0; g < LANES; g++) begin
      if (wr_en && wr_lane_en[g]) begin
        mem[wr_addr][g*LANE_W +: LANE_W] <= wr_data[g*LANE_W +: LANE_W];
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    if (rd_en) begin
      st_next.rd_data = mem[rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // sss_mem
`default_nettype wire

// ### logic/sss_pkg.sv
// Constants and types shared by the split-port synchronous memory interface
package sss_pkg;

  localparam int DATA_W      = 18;
  localparam int ADDR_W      = 20;
  localparam int BEAT_W      = 2;
  localparam int WORD_ADDR_W = ADDR_W + BEAT_W;
  localparam int LANES       = 2;
  localparam int LANE_W      = 9;
  localparam int FIFO_DEPTH  = 16;
  localparam int WR_ENTRY_W  = WORD_ADDR_W + LANES + DATA_W;
  localparam int PIPE_LEN    = 9;

  localparam logic [2:0] BURST_LEN      = 3'h4;
  localparam int         LAT_PLL_HALF   = 5;
  localparam int         LAT_NOPLL_HALF = 2;

  localparam logic [DATA_W-1:0] RD_DATA_RESET = 18'h0_0000;
  localparam logic              OE_N_RESET    = 1'b1;

  typedef enum logic [1:0] {
    SSS_FETCH_IDLE = 2'b01,
    SSS_FETCH_RUN  = 2'b10
  } sss_fetch_type;

endpackage : sss_pkg
